// ### logic/sgsc_pkg.sv
`default_nettype none
package sgsc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Time base
  localparam int CLK_FREQ_HZ = 25_000_000;
  localparam int CLK_PER_MS = CLK_FREQ_HZ / 1000;
  localparam int POR_TIME_MS = 100;
  localparam int POR_CYCLES = POR_TIME_MS * CLK_PER_MS;
  localparam int ZC_TIMEOUT_MS = 16;
  localparam int ZC_TIMEOUT_CYCLES = ZC_TIMEOUT_MS * CLK_PER_MS;
  // Length of one offset calibration run
  localparam int CAL_CYCLES = 1024;

  ////////////////////////////////////////////////////////////////////////////
  // Serial word layout
  localparam int WORD_BITS = 16;
  localparam int CODE_BITS = 8;
  localparam int WORD_MSB = 15;
  localparam int RIGHT_MSB = 15;
  localparam int RIGHT_LSB = 8;
  localparam int LEFT_MSB = 7;
  localparam int LEFT_LSB = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and gain coding
  localparam logic [15:0] SHIFT_RESET = 16'h0000;
  localparam logic [3:0] BIT_CNT_RESET = 4'h0;
  localparam logic [3:0] BIT_CNT_FIRST = 4'h1;
  localparam logic [7:0] CODE_MUTE = 8'h00;
  localparam logic [7:0] CODE_RESET = 8'h00;
  localparam logic [8:0] UNITY_HALF_DB = 9'h000;
  // Half-dB gain is code minus 192: 255 gives +63 (31.5 dB), 1 gives -191
  localparam logic [8:0] GAIN_OFFSET_HALF_DB = 9'h0c0;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef struct packed {
    logic [7:0] right;
    logic [7:0] left;
  } sgsc_word_t;

  typedef struct packed {
    logic [7:0] code;
    logic [8:0] half_db;
    logic ground;
    logic muted;
  } sgsc_chan_stat_t;

  typedef enum logic [2:0] {
    ST_POR,
    ST_CAL,
    ST_RUN,
    ST_MUTE_CAL,
    ST_UNDERVOLT
  } sgsc_pwr_t;

endpackage
`default_nettype wire

// ### logic/sgsc_chan.sv
`timescale 1ns/1ps
`default_nettype none
module sgsc_chan #(
  parameter int TIMEOUT_CYCLES = sgsc_pkg::ZC_TIMEOUT_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Sequencer hold and pin controls
  input wire logic hold,
  input wire logic defer_en,
  input wire logic mute_req,
  // New code from the serial port
  input wire logic load,
  input wire logic [7:0] load_code,
  // Synchronised zero-crossing level
  input wire logic zc_level,
  // Channel state
  output sgsc_pkg::sgsc_chan_stat_t stat
);

  localparam int TW = $clog2(TIMEOUT_CYCLES + 1);
  localparam logic [TW-1:0] T_LAST = TW'(TIMEOUT_CYCLES - 1);

  logic zc_prev_q;
  logic [7:0] code_q;
  logic [7:0] pend_code_q;
  logic pend_q;
  logic mute_pend_q;
  logic muted_q;
  logic [TW-1:0] timer_q;
  sgsc_pkg::sgsc_chan_stat_t stat_q;
  logic zc_rise;
  logic timeout;
  logic fire;
  logic changed;
  logic mute_start;

  assign zc_rise = zc_level & ~zc_prev_q;
  assign timeout = (timer_q == T_LAST);
  assign fire = zc_rise | timeout;
  assign changed = (load_code != code_q);
  assign mute_start = mute_req & ~muted_q & ~mute_pend_q;

  ////////////////////////////////////////////////////////////////////////////
  // Zero-crossing edge
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      zc_prev_q <= 1'b0;
    else
      zc_prev_q <= zc_level;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timeout counter, restarted by each new deferred request
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      timer_q <= '0;
    else if (hold || (load && changed && defer_en) || mute_start)
      timer_q <= '0;
    else if ((pend_q || mute_pend_q) && !timeout)
      timer_q <= timer_q + TW'(1);
    else
      timer_q <= '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Applied gain code
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      code_q <= sgsc_pkg::CODE_RESET;
    else if (hold)
      code_q <= sgsc_pkg::CODE_RESET;
    else if (load && changed && !defer_en)
      code_q <= load_code;
    else if (!load && pend_q && fire)
      code_q <= pend_code_q;
  end

  // Pending code waits for a crossing or the timeout
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pend_q <= 1'b0;
      pend_code_q <= sgsc_pkg::CODE_RESET;
    end
    else if (hold)
    begin
      pend_q <= 1'b0;
      pend_code_q <= sgsc_pkg::CODE_RESET;
    end
    else if (load)
    begin
      pend_q <= changed & defer_en;
      pend_code_q <= load_code;
    end
    else if (fire)
      pend_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Hardware mute engages on a crossing or timeout, whatever the defer level
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      mute_pend_q <= 1'b0;
    else if (hold || !mute_req)
      mute_pend_q <= 1'b0;
    else if (mute_start)
      mute_pend_q <= 1'b1;
    else if (fire)
      mute_pend_q <= 1'b0;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      muted_q <= 1'b1;
    else if (hold)
      muted_q <= 1'b1;
    else if (!mute_req)
      muted_q <= 1'b0;
    else if (mute_pend_q && fire)
      muted_q <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered channel state
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      stat_q.code <= sgsc_pkg::CODE_RESET;
      stat_q.half_db <= sgsc_pkg::UNITY_HALF_DB;
      stat_q.ground <= 1'b1;
      stat_q.muted <= 1'b1;
    end
    else
    begin
      stat_q.code <= code_q;
      if (code_q == sgsc_pkg::CODE_MUTE)
        stat_q.half_db <= sgsc_pkg::UNITY_HALF_DB;
      else
        stat_q.half_db <= {1'b0, code_q} - sgsc_pkg::GAIN_OFFSET_HALF_DB;
      stat_q.ground <= (code_q == sgsc_pkg::CODE_MUTE);
      stat_q.muted <= muted_q;
    end
  end

  assign stat = stat_q;

endmodule // sgsc_chan
`default_nettype wire

// ### logic/sgsc_top.sv
// What this block does
// - Internal power-up reset for 100 ms, outputs hardware-muted, state cleared.
// - Offset calibration starts by itself when power-up reset ends.
// - After calibration both gain codes are zero until the host writes.
// - Undervolt gives hardware mute; recovery reruns the whole power-up sequence.
// - Serial bits are taken only while chip select is low.
// - One transfer per device is 16 bits: two 8-bit gain codes.
// - Codes go most significant bit first, as unsigned binary.
// - Serial input is sampled on each rising serial clock edge while chip select is low.
// - Serial output is driven only while chip select is low.
// - Serial output carries bits shifted out of the 16-bit register.
// - Code zero mutes: input to analog ground, amplifier at unity.
// - Codes 1 to 255 give 31.5 dB minus half dB per step below 255.
// - Defer enable low applies gains at once; high defers them.
// - Deferral acts per channel, only when that channel's code changes.
// - Deferred gain applies at next rising zero crossing or after 16 ms.
// - Hardware mute engages at a crossing or 16 ms, ignoring defer enable.
// - Hardware mute input also starts an offset calibration.
// - Serial output changes on the falling serial clock edge.
`timescale 1ns/1ps
`default_nettype none
module sgsc_top #(
  parameter int POR_CYCLES = sgsc_pkg::POR_CYCLES,
  parameter int ZC_TIMEOUT_CYCLES = sgsc_pkg::ZC_TIMEOUT_CYCLES,
  parameter int CAL_CYCLES = sgsc_pkg::CAL_CYCLES
) (
  // System clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Serial control port
  input wire logic SCLK,
  input wire logic CS_N,
  input wire logic SERIAL_IN,
  output logic SERIAL_OUT,
  output logic SERIAL_OUT_OE,
  // Control pins
  input wire logic ZERO_CROSS_DEFER_ENABLE,
  input wire logic MUTE_N,
  // Indications from the analog section
  input wire logic ZC_RIGHT,
  input wire logic ZC_LEFT,
  input wire logic UNDERVOLT,
  // Right channel controls
  output logic [7:0] RIGHT_GAIN_CODE,
  output logic [8:0] RIGHT_GAIN_HALF_DB,
  output logic RIGHT_ANALOG_GROUND,
  output logic RIGHT_HW_MUTE,
  // Left channel controls
  output logic [7:0] LEFT_GAIN_CODE,
  output logic [8:0] LEFT_GAIN_HALF_DB,
  output logic LEFT_ANALOG_GROUND,
  output logic LEFT_HW_MUTE,
  // Sequencer state
  output logic POWERUP_RESET,
  output logic CALIBRATE
);

  localparam int CNT_MAX = (POR_CYCLES > CAL_CYCLES) ? POR_CYCLES : CAL_CYCLES;
  localparam int CW = $clog2(CNT_MAX + 1);
  localparam logic [CW-1:0] POR_LAST = CW'(POR_CYCLES - 1);
  localparam logic [CW-1:0] CAL_LAST = CW'(CAL_CYCLES - 1);
  localparam int NSYNC = 6;
  localparam int S_CS = 0;
  localparam int S_MUTE = 1;
  localparam int S_ZCR = 2;
  localparam int S_ZCL = 3;
  localparam int S_UV = 4;
  localparam int S_DEF = 5;

  ////////////////////////////////////////////////////////////////////////////
  // Serial clock domain
  logic armed_q;
  logic [15:0] shift_q;
  logic [3:0] bit_cnt_q;
  logic [3:0] bit_cnt_d;
  logic word_ok_q;
  logic sout_q;

  // Armed while chip select is high so the first edge of a frame restarts the count
  always_ff @(posedge SCLK or posedge RST or posedge CS_N)
  begin
    if (RST)
      armed_q <= 1'b1;
    else if (CS_N)
      armed_q <= 1'b1;
    else
      armed_q <= 1'b0;
  end

  always_comb
  begin
    if (armed_q)
      bit_cnt_d = sgsc_pkg::BIT_CNT_FIRST;
    else
      bit_cnt_d = bit_cnt_q + 4'h1;
  end

  always_ff @(posedge SCLK or posedge RST)
  begin
    if (RST)
    begin
      shift_q <= sgsc_pkg::SHIFT_RESET;
      bit_cnt_q <= sgsc_pkg::BIT_CNT_RESET;
      word_ok_q <= 1'b0;
    end
    else if (!CS_N)
    begin
      shift_q <= {shift_q[sgsc_pkg::WORD_MSB-1:0], SERIAL_IN};
      bit_cnt_q <= bit_cnt_d;
      word_ok_q <= (bit_cnt_d == sgsc_pkg::BIT_CNT_RESET);
    end
  end

  // Falling edge presents the bit that the next rising edge pushes out
  always_ff @(negedge SCLK or posedge RST)
  begin
    if (RST)
      sout_q <= 1'b0;
    else
      sout_q <= shift_q[sgsc_pkg::WORD_MSB];
  end

  assign SERIAL_OUT = sout_q;
  assign SERIAL_OUT_OE = ~CS_N;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers into the system clock
  logic [NSYNC-1:0] pins;
  logic [NSYNC-1:0] sync1_q;
  logic [NSYNC-1:0] sync2_q;

  assign pins = {ZERO_CROSS_DEFER_ENABLE, UNDERVOLT, ZC_LEFT, ZC_RIGHT, MUTE_N, CS_N};

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      sync1_q <= {{(NSYNC - 2){1'b0}}, 2'b11}; // Idle pin levels, no false edge or undervolt
      sync2_q <= {{(NSYNC - 2){1'b0}}, 2'b11};
    end
    else
    begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
    end
  end

  logic cs_n_s;
  logic mute_n_s;
  logic uv_s;
  logic defer_s;

  assign cs_n_s = sync2_q[S_CS];
  assign mute_n_s = sync2_q[S_MUTE];
  assign uv_s = sync2_q[S_UV];
  assign defer_s = sync2_q[S_DEF];

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection on synchronised levels
  logic cs_n_prev_q;
  logic mute_n_prev_q;
  logic cs_rise;
  logic mute_fall;

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      cs_n_prev_q <= 1'b1;
      mute_n_prev_q <= 1'b1;
    end
    else
    begin
      cs_n_prev_q <= cs_n_s;
      mute_n_prev_q <= mute_n_s;
    end
  end

  assign cs_rise = cs_n_s & ~cs_n_prev_q;
  assign mute_fall = ~mute_n_s & mute_n_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // Power sequencer
  sgsc_pkg::sgsc_pwr_t state_q;
  sgsc_pkg::sgsc_pwr_t state_d;
  logic [CW-1:0] pwr_cnt_q;
  logic running;

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      sgsc_pkg::ST_POR:
      begin
        if (uv_s)
          state_d = sgsc_pkg::ST_UNDERVOLT;
        else if (pwr_cnt_q == POR_LAST)
          state_d = sgsc_pkg::ST_CAL;
      end
      sgsc_pkg::ST_CAL:
      begin
        if (uv_s)
          state_d = sgsc_pkg::ST_UNDERVOLT;
        else if (pwr_cnt_q == CAL_LAST)
          state_d = sgsc_pkg::ST_RUN;
      end
      sgsc_pkg::ST_RUN:
      begin
        if (uv_s)
          state_d = sgsc_pkg::ST_UNDERVOLT;
        else if (mute_fall)
          state_d = sgsc_pkg::ST_MUTE_CAL;
      end
      sgsc_pkg::ST_MUTE_CAL:
      begin
        if (uv_s)
          state_d = sgsc_pkg::ST_UNDERVOLT;
        else if (pwr_cnt_q == CAL_LAST)
          state_d = sgsc_pkg::ST_RUN;
      end
      sgsc_pkg::ST_UNDERVOLT:
      begin
        if (!uv_s)
          state_d = sgsc_pkg::ST_POR;
      end
      default:
        state_d = sgsc_pkg::ST_POR;
    endcase
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      state_q <= sgsc_pkg::ST_POR;
    else
      state_q <= state_d;
  end

  // Phase timer restarts at every state change
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      pwr_cnt_q <= '0;
    else if (state_d != state_q)
      pwr_cnt_q <= '0;
    else if ((state_q == sgsc_pkg::ST_POR) || (state_q == sgsc_pkg::ST_CAL)
             || (state_q == sgsc_pkg::ST_MUTE_CAL))
      pwr_cnt_q <= pwr_cnt_q + CW'(1);
  end

  assign running = (state_q == sgsc_pkg::ST_RUN) || (state_q == sgsc_pkg::ST_MUTE_CAL);

  logic por_q;
  logic cal_q;
  logic hold_q;

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      por_q <= 1'b1;
      cal_q <= 1'b0;
      hold_q <= 1'b1;
    end
    else
    begin
      por_q <= (state_d == sgsc_pkg::ST_POR);
      cal_q <= (state_d == sgsc_pkg::ST_CAL) || (state_d == sgsc_pkg::ST_MUTE_CAL);
      hold_q <= (state_d == sgsc_pkg::ST_POR) || (state_d == sgsc_pkg::ST_CAL)
                || (state_d == sgsc_pkg::ST_UNDERVOLT);
    end
  end

  assign POWERUP_RESET = por_q;
  assign CALIBRATE = cal_q;

  ////////////////////////////////////////////////////////////////////////////
  // Word capture: the shift register is idle once chip select is high
  sgsc_pkg::sgsc_word_t word_q;
  logic load_q;

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      word_q <= sgsc_pkg::SHIFT_RESET;
      load_q <= 1'b0;
    end
    else
    begin
      load_q <= cs_rise & word_ok_q & running & ~hold_q;
      if (cs_rise)
        word_q <= shift_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channels
  sgsc_pkg::sgsc_chan_stat_t right_stat;
  sgsc_pkg::sgsc_chan_stat_t left_stat;

  sgsc_chan #(
    .TIMEOUT_CYCLES(ZC_TIMEOUT_CYCLES)
  ) u_right (
    .clk(CLK),
    .rst(RST),
    .hold(hold_q),
    .defer_en(defer_s),
    .mute_req(~mute_n_s),
    .load(load_q),
    .load_code(word_q.right),
    .zc_level(sync2_q[S_ZCR]),
    .stat(right_stat)
  );

  sgsc_chan #(
    .TIMEOUT_CYCLES(ZC_TIMEOUT_CYCLES)
  ) u_left (
    .clk(CLK),
    .rst(RST),
    .hold(hold_q),
    .defer_en(defer_s),
    .mute_req(~mute_n_s),
    .load(load_q),
    .load_code(word_q.left),
    .zc_level(sync2_q[S_ZCL]),
    .stat(left_stat)
  );

  assign RIGHT_GAIN_CODE = right_stat.code;
  assign RIGHT_GAIN_HALF_DB = right_stat.half_db;
  assign RIGHT_ANALOG_GROUND = right_stat.ground;
  assign RIGHT_HW_MUTE = right_stat.muted;
  assign LEFT_GAIN_CODE = left_stat.code;
  assign LEFT_GAIN_HALF_DB = left_stat.half_db;
  assign LEFT_ANALOG_GROUND = left_stat.ground;
  assign LEFT_HW_MUTE = left_stat.muted;

endmodule // sgsc_top
`default_nettype wire

// ### testbench/sgsc_checker_properties.sv
`timescale 1ns/1ps
`default_nettype none
module sgsc_checker #(
  parameter int ZC_TIMEOUT_CYCLES = sgsc_pkg::ZC_TIMEOUT_CYCLES
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Pins
  input wire logic CS_N,
  input wire logic SERIAL_OUT_OE,
  input wire logic MUTE_N,
  input wire logic UNDERVOLT,
  // Channel outputs
  input wire logic [7:0] RIGHT_GAIN_CODE,
  input wire logic [8:0] RIGHT_GAIN_HALF_DB,
  input wire logic RIGHT_ANALOG_GROUND,
  input wire logic RIGHT_HW_MUTE,
  input wire logic [7:0] LEFT_GAIN_CODE,
  input wire logic [8:0] LEFT_GAIN_HALF_DB,
  input wire logic LEFT_ANALOG_GROUND,
  input wire logic LEFT_HW_MUTE,
  // Sequencer
  input wire logic POWERUP_RESET,
  input wire logic CALIBRATE
);
  // Timeout plus input synchronisers and output flop
  localparam int MUTE_MAX = ZC_TIMEOUT_CYCLES + 8;
  int mute_cnt_q;

  default clocking @(posedge CLK);
  endclocking
  default disable iff (RST);

  ////////////////////////////////////////////////////////////////////////////
  // Cycles the mute input has been held low, saturating
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      mute_cnt_q <= 0;
    end
    else if (MUTE_N)
    begin
      mute_cnt_q <= 0;
    end
    else if (mute_cnt_q < MUTE_MAX)
    begin
      mute_cnt_q <= mute_cnt_q + 1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  AST_OE_CS: assert property (SERIAL_OUT_OE == !CS_N)
    else $error("serial output enable does not follow chip select");
  AST_POR_MUTE: assert property (POWERUP_RESET |-> RIGHT_HW_MUTE && LEFT_HW_MUTE)
    else $error("outputs not muted during power-up reset");
  AST_POR_CLEAR: assert property (POWERUP_RESET |-> !CALIBRATE &&
      RIGHT_GAIN_CODE == 8'h00 && LEFT_GAIN_CODE == 8'h00)
    else $error("state not cleared during power-up reset");
  AST_CAL_START: assert property ($fell(POWERUP_RESET) && !UNDERVOLT |-> ##[0:3] CALIBRATE)
    else $error("calibration did not follow power-up reset");
  AST_UV_MUTE: assert property (UNDERVOLT [*8] |-> RIGHT_HW_MUTE && LEFT_HW_MUTE)
    else $error("undervolt did not mute");
  AST_UV_RERUN: assert property (UNDERVOLT [*8] ##1 !UNDERVOLT |-> ##[0:6] POWERUP_RESET)
    else $error("supply recovery did not rerun power-up");
  AST_ZERO_GND: assert property (RIGHT_GAIN_CODE == 8'h00 && LEFT_GAIN_CODE == 8'h00 |->
      RIGHT_ANALOG_GROUND && LEFT_ANALOG_GROUND && RIGHT_GAIN_HALF_DB == 9'h000 &&
      LEFT_GAIN_HALF_DB == 9'h000)
    else $error("code zero not grounded at unity");
  AST_HALF_DB: assert property (RIGHT_GAIN_CODE != 8'h00 |-> !RIGHT_ANALOG_GROUND &&
      RIGHT_GAIN_HALF_DB == {1'b0, RIGHT_GAIN_CODE} - 9'h0c0)
    else $error("right gain step wrong");
  AST_MUTE_TIMEOUT: assert property (mute_cnt_q == MUTE_MAX |->
      RIGHT_HW_MUTE && LEFT_HW_MUTE)
    else $error("hardware mute not engaged by timeout");
  AST_MUTE_CAL: assert property ($fell(MUTE_N) && !POWERUP_RESET && !CALIBRATE &&
      !UNDERVOLT |-> ##[1:6] CALIBRATE)
    else $error("mute did not start calibration");
endmodule // sgsc_checker
`default_nettype wire

// ### testbench/sgsc_host.sv
`timescale 1ns/1ps
`default_nettype none
module sgsc_host (
  // Link pins
  output logic sclk,
  output logic cs_n,
  output logic serial_in,
  input wire logic serial_out,
  // Bits a next chained device would have sampled
  output logic [15:0] so_cap
);
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    serial_in = 1'b0;
    so_cap = 16'h0000;
  end

  always @(posedge sclk)
  begin
    so_cap <= {so_cap[14:0], serial_out};
  end

  // Clock stands still outside the frame; data changes while clock is low
  task automatic send(input logic [31:0] w, input int n);
    cs_n = 1'b0;
    #9;
    for (int i = n - 1; i >= 0; i--)
    begin
      serial_in = w[i];
      #3 sclk = 1'b1;
      #3 sclk = 1'b0;
    end
    #3 cs_n = 1'b1;
    serial_in = ~serial_in;
  endtask

  // Clock pulses while deselected
  task automatic stray(input int n);
    for (int i = 0; i < n; i++)
    begin
      serial_in = ~serial_in;
      #3 sclk = 1'b1;
      #3 sclk = 1'b0;
    end
  endtask
endmodule // sgsc_host
`default_nettype wire

// ### testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) \
  begin \
    compares++; \
    if ((a) !== (e)) \
    begin \
      err_count++; \
      $display("unexpected at %0t: got %0h expected %0h", $time, (a), (e)); \
    end \
  end
module tb;
  localparam int POR = 200;
  localparam int ZCT = 50;
  localparam int CAL = 20;
  logic clk, rst, sclk, cs_n, sdat, so, so_oe, defer, mute_n, zc_r, zc_l, uv, por, cal;
  logic r_gnd, l_gnd, r_mute, l_mute;
  logic [7:0] r_code, l_code;
  logic [8:0] r_db, l_db;
  logic [15:0] so_cap, w1, w2;
  // Released serial output floats, so a late enable shows up in the capture
  wire logic so_bus;
  assign so_bus = so_oe ? so : 1'bz;
  int err_count = 0;
  int compares = 0;
  int exp_r, exp_l, nr, nl;

  sgsc_top #(.POR_CYCLES(POR), .ZC_TIMEOUT_CYCLES(ZCT), .CAL_CYCLES(CAL)) i_dut (
    .CLK(clk), .RST(rst), .SCLK(sclk), .CS_N(cs_n), .SERIAL_IN(sdat), .SERIAL_OUT(so),
    .SERIAL_OUT_OE(so_oe), .ZERO_CROSS_DEFER_ENABLE(defer), .MUTE_N(mute_n),
    .ZC_RIGHT(zc_r), .ZC_LEFT(zc_l), .UNDERVOLT(uv),
    .RIGHT_GAIN_CODE(r_code), .RIGHT_GAIN_HALF_DB(r_db), .RIGHT_ANALOG_GROUND(r_gnd),
    .RIGHT_HW_MUTE(r_mute), .LEFT_GAIN_CODE(l_code), .LEFT_GAIN_HALF_DB(l_db),
    .LEFT_ANALOG_GROUND(l_gnd), .LEFT_HW_MUTE(l_mute), .POWERUP_RESET(por), .CALIBRATE(cal)
  );
  sgsc_host i_host (.sclk(sclk), .cs_n(cs_n), .serial_in(sdat), .serial_out(so_bus),
    .so_cap(so_cap));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check_all();
    `CHK(r_code, 8'(exp_r))
    `CHK(l_code, 8'(exp_l))
    `CHK(r_db, 9'(exp_r == 0 ? 0 : exp_r - 192))
    `CHK(l_db, 9'(exp_l == 0 ? 0 : exp_l - 192))
    `CHK({r_gnd, l_gnd}, {exp_r == 0, exp_l == 0})
  endtask

  task automatic wait_cal(input logic lvl);
    int k;
    k = 0;
    while (cal !== lvl && k < 1000)
    begin
      @(posedge clk);
      k++;
    end
    `CHK(cal, lvl)
  endtask

  // Deferred writes leave the model's applied codes alone
  task automatic wr(input int r, input int l);
    i_host.send({16'h0000, 8'(r), 8'(l)}, 16);
    if (!defer)
    begin
      exp_r = r;
      exp_l = l;
    end
    repeat (8) @(posedge clk);
  endtask

  task automatic report_and_stop();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
    begin
      $display("ALL TESTS PASSED");
    end
    else
    begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'hf6930f9c));
    {rst, mute_n} = 2'b11;
    {defer, zc_r, zc_l, uv} = 4'h0;
    exp_r = 0;
    exp_l = 0;
    repeat (5) @(posedge clk);
    `CHK({por, r_mute, l_mute}, 3'b111)
    rst <= 1'b0;
    repeat (POR - 10) @(posedge clk);
    `CHK({por, cal}, 2'b10)
    wait_cal(1'b1);
    wait_cal(1'b0);
    check_all();
    // Boundary codes first, then random ones
    for (int i = 0; i < 10; i++)
    begin
      nr = (i == 0) ? 0 : (i == 1) ? 1 : (i == 2) ? 255 : $urandom_range(255);
      nl = (i < 3) ? 255 - nr : $urandom_range(255);
      wr(nr, nl);
      check_all();
    end
    w1 = 16'($urandom);
    w2 = 16'($urandom);
    i_host.stray(16);
    i_host.send({16'h0000, w1}, 12);
    repeat (8) @(posedge clk);
    check_all();
    i_host.send({w1, w2}, 32);
    exp_r = w2[15:8];
    exp_l = w2[7:0];
    repeat (8) @(posedge clk);
    check_all();
    `CHK(so_cap, w1)
    // Deferred update: right by crossing, left by timeout
    defer <= 1'b1;
    repeat (4) @(posedge clk);
    nr = exp_r ^ 8'h5a;
    nl = exp_l ^ 8'ha5;
    wr(nr, nl);
    check_all();
    zc_r <= 1'b1;
    repeat (2) @(posedge clk);
    zc_r <= 1'b0;
    repeat (6) @(posedge clk);
    exp_r = nr;
    check_all();
    repeat (ZCT) @(posedge clk);
    exp_l = nl;
    check_all();
    // Hardware mute with defer off
    defer <= 1'b0;
    mute_n <= 1'b0;
    wait_cal(1'b1);
    `CHK(r_mute | l_mute, 1'b0)
    {zc_r, zc_l} <= 2'b11;
    repeat (8) @(posedge clk);
    `CHK({r_mute, l_mute}, 2'b11)
    check_all();
    {zc_r, zc_l} <= 2'b00;
    wait_cal(1'b0);
    repeat (ZCT) @(posedge clk);
    mute_n <= 1'b1;
    repeat (6) @(posedge clk);
    `CHK({r_mute, l_mute}, 2'b00)
    // Hardware mute with no crossing: the timeout engages it
    mute_n <= 1'b0;
    repeat (ZCT + 8) @(posedge clk);
    `CHK({r_mute, l_mute}, 2'b11)
    mute_n <= 1'b1;
    repeat (6) @(posedge clk);
    `CHK({r_mute, l_mute}, 2'b00)
    // Undervolt and recovery
    uv <= 1'b1;
    repeat (10) @(posedge clk);
    `CHK({r_mute, l_mute}, 2'b11)
    uv <= 1'b0;
    repeat (6) @(posedge clk);
    `CHK(por, 1'b1)
    exp_r = 0;
    exp_l = 0;
    wait_cal(1'b1);
    wait_cal(1'b0);
    check_all();
    report_and_stop();
  end

  initial
  begin
    #800000;
    err_count++;
    report_and_stop();
  end
endmodule // tb
bind sgsc_top sgsc_checker #(.ZC_TIMEOUT_CYCLES(ZC_TIMEOUT_CYCLES)) i_chk (
  .CLK(CLK), .RST(RST), .CS_N(CS_N), .SERIAL_OUT_OE(SERIAL_OUT_OE), .MUTE_N(MUTE_N),
  .UNDERVOLT(UNDERVOLT), .RIGHT_GAIN_CODE(RIGHT_GAIN_CODE),
  .RIGHT_GAIN_HALF_DB(RIGHT_GAIN_HALF_DB), .RIGHT_ANALOG_GROUND(RIGHT_ANALOG_GROUND),
  .RIGHT_HW_MUTE(RIGHT_HW_MUTE), .LEFT_GAIN_CODE(LEFT_GAIN_CODE),
  .LEFT_GAIN_HALF_DB(LEFT_GAIN_HALF_DB), .LEFT_ANALOG_GROUND(LEFT_ANALOG_GROUND),
  .LEFT_HW_MUTE(LEFT_HW_MUTE), .POWERUP_RESET(POWERUP_RESET), .CALIBRATE(CALIBRATE)
);
`default_nettype wire
